// *** src/bbf_pkg.sv ***
// How it works
// RULE_01: Opcode 19 scans right to left for unequal
// RULE_02: Scan index is signed low 48 bits
// RULE_03: Right scan hit decrements index by passed
// RULE_04: Descriptor holds length high, base low
// RULE_05: Right scan starts base+len+index-1, bytes shifted
// RULE_06: Right scan miss sets data flag 53
// RULE_07: Opcodes 28/29 scan left for equal/unequal
// RULE_08: Left scan hit adds passed bytes
// RULE_09: Left scan miss adds length, sets flag
// RULE_10: Opcode 1A fills field with immediate byte
// RULE_11: Opcode 1B fills with register low byte
// RULE_12: Opcodes 1C/1D write repeated lead/period mask
// RULE_13: Zero period makes mask a no-op
// RULE_14: Lead equal period or zero gives solid
// RULE_15: Software clears low 48 bits of R, S
// RULE_16: Opcode 1E counts bits equal to leftmost
// RULE_17: Bit field start is base plus index
// RULE_18: No differing bit stores length minus one
// RULE_19: Count clears register, flag if lead one
// RULE_20: Opcode 1F counts ones into cleared register
// RULE_21: Word splits into function, R, S, T
package bbf_pkg;
  localparam int unsigned WORD_W = 64;
  localparam int unsigned ADDR_W = 48;
  localparam int unsigned LEN_W = 16;
  localparam int unsigned DES_W = 8;
  localparam int unsigned FC_LSB = 24;
  localparam int unsigned RD_LSB = 16;
  localparam int unsigned SD_LSB = 8;
  localparam int unsigned TD_LSB = 0;
  localparam int unsigned LEN_LSB = 48;
  localparam int unsigned BYTE_SHIFT = 3;
  localparam logic [7:0] OP_SCAN_RIGHT = 8'h19;
  localparam logic [7:0] OP_SCAN_EQ = 8'h28;
  localparam logic [7:0] OP_SCAN_NE = 8'h29;
  localparam logic [7:0] OP_FILL_IMM = 8'h1a;
  localparam logic [7:0] OP_FILL_REG = 8'h1b;
  localparam logic [7:0] OP_MASK_ZERO = 8'h1c;
  localparam logic [7:0] OP_MASK_ONE = 8'h1d;
  localparam logic [7:0] OP_COUNT_LEAD = 8'h1e;
  localparam logic [7:0] OP_COUNT_ONES = 8'h1f;
  localparam logic [5:0] DF_FIELD_BIT = 6'h35;
  localparam logic [ADDR_W-1:0] BYTE_STEP = 48'h8;
  localparam logic [ADDR_W-1:0] BIT_STEP = 48'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 48'h0;
  localparam logic [WORD_W-1:0] WORD_RST = 64'h0;
  localparam logic [LEN_W-1:0] LEN_RST = 16'h0;
  localparam logic [7:0] BYTE_RST = 8'h0;

  function automatic logic f_op_scan(input logic [7:0] op);
    return op == OP_SCAN_RIGHT || op == OP_SCAN_EQ || op == OP_SCAN_NE;
  endfunction

  function automatic logic f_op_fill(input logic [7:0] op);
    return op == OP_FILL_IMM || op == OP_FILL_REG;
  endfunction

  function automatic logic f_op_mask(input logic [7:0] op);
    return op == OP_MASK_ZERO || op == OP_MASK_ONE;
  endfunction

  function automatic logic f_op_bitcnt(input logic [7:0] op);
    return op == OP_COUNT_LEAD || op == OP_COUNT_ONES;
  endfunction

  // Mask bit at a phase inside one period
  function automatic logic f_mask_bit(input logic [LEN_W-1:0] ph,
                                      input logic [LEN_W-1:0] lead,
                                      input logic ones);
    return (ph < lead) ? ones : !ones;
  endfunction
endpackage

// *** src/bbf_agen_if.sv ***
`timescale 1ns/1ps
interface bbf_agen_if;
  import bbf_pkg::*;
  logic [7:0] op;
  logic [WORD_W-1:0] desc;
  logic [ADDR_W-1:0] idx;
  logic [ADDR_W-1:0] start;
  modport requester (output op, output desc, output idx, input start);
  modport provider (input op, input desc, input idx, output start);
endinterface

// *** src/bbf_agen.sv ***
`timescale 1ns/1ps
module bbf_agen
  import bbf_pkg::*;
(
  bbf_agen_if.provider ag // Operand in, start address out
);
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] len_ext;
  logic [ADDR_W-1:0] right_items;

  assign base = ag.desc[ADDR_W-1:0]; // [RULE_04]
  assign len_ext = {32'h0, ag.desc[WORD_W-1:LEN_LSB]}; // [RULE_04]
  assign right_items = len_ext + ag.idx - 48'h1;

  always_comb begin
    if (ag.op == OP_SCAN_RIGHT) begin
      ag.start = base + (right_items << BYTE_SHIFT); // [RULE_05]
    end else if (f_op_scan(ag.op) || f_op_fill(ag.op)) begin
      ag.start = base + (ag.idx << BYTE_SHIFT); // [RULE_10]
    end else if (f_op_bitcnt(ag.op)) begin
      ag.start = base + ag.idx; // [RULE_17]
    end else begin
      ag.start = base;
    end
  end
endmodule // bbf_agen

// *** src/bbf_unit.sv ***
`timescale 1ns/1ps
module bbf_unit
  import bbf_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i, // Sync reset, high
  input wire logic ce_i, // Clock enable
  input wire logic start_i, // Issue instruction
  input wire logic [31:0] instr_i, // Instruction word
  output logic ready_o, // Idle, can issue
  output logic done_o, // Instruction finished
  output logic [DES_W-1:0] reg_raddr_o, // Register read select
  input wire logic [WORD_W-1:0] reg_rdata_i, // Register read data
  output logic reg_we_o, // Register write strobe
  output logic [DES_W-1:0] reg_waddr_o, // Register write select
  output logic [WORD_W-1:0] reg_wdata_o, // Register write data
  output logic mem_req_o, // Memory request
  output logic mem_we_o, // Memory write
  output logic mem_bit_o, // Single-bit access
  output logic [ADDR_W-1:0] mem_addr_o, // Bit address
  output logic [7:0] mem_wdata_o, // Write data
  input wire logic [7:0] mem_rdata_i, // Read data
  input wire logic mem_ack_i, // Memory done
  output logic df_set_o, // Data flag set pulse
  output logic [5:0] df_bit_o // Data flag number
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_R, ST_RD_S, ST_RD_T, ST_SETUP, ST_MEM, ST_WB, ST_DONE
  } bbf_state_t;

  bbf_state_t state_q;
  logic [7:0] fc_q;
  logic [DES_W-1:0] rdes_q;
  logic [DES_W-1:0] sdes_q;
  logic [DES_W-1:0] tdes_q;
  logic [WORD_W-1:0] r_q;
  logic [WORD_W-1:0] s_q;
  logic [WORD_W-1:0] t_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [LEN_W-1:0] pos_q;
  logic [LEN_W-1:0] ph_q;
  logic [LEN_W-1:0] ph_d;
  logic [LEN_W-1:0] cnt_q;
  logic lead_q;
  logic hit_q;
  logic [7:0] wdata_q;
  logic [WORD_W-1:0] rwdata_q;
  logic [DES_W-1:0] rwaddr_q;
  logic rwe_q;
  logic df_q;

  logic is_scan;
  logic is_fill;
  logic is_mask;
  logic is_bitcnt;
  logic mask_ones;
  logic [WORD_W-1:0] desc;
  logic [LEN_W-1:0] len;
  logic [ADDR_W-1:0] idx;
  logic [LEN_W-1:0] period;
  logic [LEN_W-1:0] lead_len;
  logic at_end;
  logic acc;
  logic scan_hit;
  logic lead_break;
  logic stop;
  logic noop;

  bbf_agen_if ag ();

  bbf_agen bbf_agen_inst (
    .ag (ag.provider)
  );

  assign is_scan = f_op_scan(fc_q);
  assign is_fill = f_op_fill(fc_q);
  assign is_mask = f_op_mask(fc_q);
  assign is_bitcnt = f_op_bitcnt(fc_q);
  assign mask_ones = fc_q == OP_MASK_ONE;
  // Counting ops keep their field in R, others in T
  assign desc = is_bitcnt ? r_q : t_q; // [RULE_17]
  assign len = desc[WORD_W-1:LEN_LSB]; // [RULE_04]
  assign idx = s_q[ADDR_W-1:0]; // [RULE_02] [RULE_20]
  // Only the upper 16 bits matter for the mask lengths
  assign period = s_q[WORD_W-1:LEN_LSB]; // [RULE_12] [RULE_15]
  assign lead_len = r_q[WORD_W-1:LEN_LSB]; // [RULE_12]
  assign noop = is_mask && period == LEN_RST; // [RULE_13]

  assign ag.op = fc_q;
  assign ag.desc = desc;
  assign ag.idx = idx;

  assign at_end = pos_q == len;
  assign acc = state_q == ST_MEM && ce_i && !at_end && mem_ack_i;
  always_comb begin
    case (fc_q)
      OP_SCAN_RIGHT: scan_hit = mem_rdata_i != rdes_q; // [RULE_01]
      OP_SCAN_EQ: scan_hit = mem_rdata_i == rdes_q; // [RULE_07]
      OP_SCAN_NE: scan_hit = mem_rdata_i != rdes_q; // [RULE_07]
      default: scan_hit = 1'b0;
    endcase
  end
  // Scan starts one bit after the leftmost bit
  assign lead_break = fc_q == OP_COUNT_LEAD && pos_q != LEN_RST &&
                      mem_rdata_i[0] != lead_q; // [RULE_16]
  assign stop = acc && (scan_hit || lead_break); // [RULE_03] [RULE_08]

  always_comb begin
    if (fc_q == OP_SCAN_RIGHT) begin
      addr_d = addr_q - BYTE_STEP; // [RULE_01]
    end else if (is_scan || is_fill) begin
      addr_d = addr_q + BYTE_STEP; // [RULE_07]
    end else begin
      addr_d = addr_q + BIT_STEP;
    end
  end
  assign ph_d = (ph_q + 16'h1 == period) ? LEN_RST : ph_q + 16'h1;

  // Sequencer
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else if (ce_i) begin
      case (state_q)
        ST_IDLE: begin
          if (start_i) begin
            state_q <= ST_RD_R;
          end
        end
        ST_RD_R: state_q <= ST_RD_S;
        ST_RD_S: state_q <= ST_RD_T;
        ST_RD_T: state_q <= ST_SETUP;
        ST_SETUP: begin
          state_q <= noop ? ST_DONE : ST_MEM; // [RULE_13]
        end
        ST_MEM: begin
          if (at_end || stop) begin
            state_q <= ST_WB; // [RULE_06] [RULE_09]
          end
        end
        ST_WB: state_q <= ST_DONE;
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Instruction fields and operand capture
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fc_q <= BYTE_RST;
      rdes_q <= BYTE_RST;
      sdes_q <= BYTE_RST;
      tdes_q <= BYTE_RST;
      r_q <= WORD_RST;
      s_q <= WORD_RST;
      t_q <= WORD_RST;
    end else if (ce_i) begin
      if (state_q == ST_IDLE && start_i) begin
        fc_q <= instr_i[FC_LSB +: 8]; // [RULE_21]
        rdes_q <= instr_i[RD_LSB +: DES_W]; // [RULE_21]
        sdes_q <= instr_i[SD_LSB +: DES_W]; // [RULE_21]
        tdes_q <= instr_i[TD_LSB +: DES_W]; // [RULE_21]
      end
      if (state_q == ST_RD_R) begin
        r_q <= reg_rdata_i;
      end
      if (state_q == ST_RD_S) begin
        s_q <= reg_rdata_i;
      end
      if (state_q == ST_RD_T) begin
        t_q <= reg_rdata_i;
      end
    end
  end

  // Field walk: address, position, mask phase, write data
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      addr_q <= ADDR_RST;
      pos_q <= LEN_RST;
      ph_q <= LEN_RST;
      wdata_q <= BYTE_RST;
      hit_q <= 1'b0;
    end else if (ce_i) begin
      if (state_q == ST_SETUP) begin
        addr_q <= ag.start; // [RULE_05]
        pos_q <= LEN_RST;
        ph_q <= LEN_RST;
        hit_q <= 1'b0;
        if (fc_q == OP_FILL_IMM) begin
          wdata_q <= rdes_q; // [RULE_10]
        end else if (fc_q == OP_FILL_REG) begin
          wdata_q <= r_q[7:0]; // [RULE_11]
        end else begin
          wdata_q <= {7'h0, f_mask_bit(LEN_RST, lead_len, mask_ones)};
        end
      end else if (stop) begin
        hit_q <= 1'b1;
      end else if (acc) begin
        addr_q <= addr_d;
        pos_q <= pos_q + 16'h1;
        if (is_mask) begin
          ph_q <= ph_d;
          wdata_q <= {7'h0,
                      f_mask_bit(ph_d, lead_len, mask_ones)}; // [RULE_14]
        end
      end
    end
  end

  // Bit counters
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_q <= LEN_RST;
      lead_q <= 1'b0;
    end else if (ce_i) begin
      if (state_q == ST_SETUP) begin
        cnt_q <= LEN_RST;
        lead_q <= 1'b0;
      end else if (acc && !stop) begin
        if (fc_q == OP_COUNT_ONES) begin
          cnt_q <= cnt_q + {15'h0, mem_rdata_i[0]}; // [RULE_20]
        end else if (fc_q == OP_COUNT_LEAD) begin
          if (pos_q == LEN_RST) begin
            lead_q <= mem_rdata_i[0];
          end else begin
            cnt_q <= cnt_q + 16'h1; // [RULE_16] [RULE_18]
          end
        end
      end
    end
  end

  // Result formation
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rwdata_q <= WORD_RST;
      rwaddr_q <= BYTE_RST;
      rwe_q <= 1'b0;
      df_q <= 1'b0;
    end else if (ce_i) begin
      if (state_q == ST_SETUP) begin
        rwe_q <= 1'b0;
        df_q <= 1'b0;
      end else if (state_q == ST_WB) begin
        if (is_scan) begin
          rwaddr_q <= sdes_q;
          rwe_q <= 1'b1;
          df_q <= !hit_q; // [RULE_06] [RULE_09]
          if (fc_q == OP_SCAN_RIGHT) begin
            rwdata_q <= {s_q[WORD_W-1:LEN_LSB],
                         idx - {32'h0, pos_q}}; // [RULE_03]
          end else begin
            rwdata_q <= {s_q[WORD_W-1:LEN_LSB],
                         idx + {32'h0, pos_q}}; // [RULE_08] [RULE_09]
          end
        end else if (is_bitcnt) begin
          rwaddr_q <= tdes_q;
          rwe_q <= 1'b1;
          rwdata_q <= {48'h0, cnt_q}; // [RULE_19] [RULE_20]
          df_q <= fc_q == OP_COUNT_LEAD && lead_q; // [RULE_19]
        end else begin
          rwe_q <= 1'b0;
          df_q <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    case (state_q)
      ST_RD_R: reg_raddr_o = rdes_q;
      ST_RD_S: reg_raddr_o = sdes_q;
      ST_RD_T: reg_raddr_o = tdes_q;
      default: reg_raddr_o = BYTE_RST;
    endcase
  end

  assign ready_o = state_q == ST_IDLE;
  assign done_o = state_q == ST_DONE;
  assign reg_we_o = done_o && rwe_q;
  assign reg_waddr_o = rwaddr_q;
  assign reg_wdata_o = rwdata_q;
  assign df_set_o = done_o && df_q;
  assign df_bit_o = DF_FIELD_BIT;
  assign mem_req_o = state_q == ST_MEM && ce_i && !at_end;
  assign mem_we_o = is_fill || is_mask;
  assign mem_bit_o = is_mask || is_bitcnt;
  assign mem_addr_o = addr_q;
  assign mem_wdata_o = wdata_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_right_step_back: assert property ( // [RULE_01]
    acc && !stop && fc_q == OP_SCAN_RIGHT
    |=> mem_addr_o == $past(mem_addr_o) - BYTE_STEP)
    else $error("right scan address did not step back a byte");
  a_left_step_fwd: assert property ( // [RULE_07]
    acc && !stop && is_scan && fc_q != OP_SCAN_RIGHT
    |=> mem_addr_o == $past(mem_addr_o) + BYTE_STEP)
    else $error("left scan address did not step forward a byte");
  a_first_addr: assert property ( // [RULE_05]
    state_q == ST_SETUP && ce_i && !noop
    |=> mem_addr_o == $past(ag.start) && pos_q == LEN_RST)
    else $error("first address not taken from generator");
  a_fill_imm_byte: assert property ( // [RULE_10]
    mem_req_o && fc_q == OP_FILL_IMM
    |-> mem_we_o && mem_wdata_o == rdes_q)
    else $error("immediate fill wrote wrong byte");
  a_fill_reg_byte: assert property ( // [RULE_11]
    mem_req_o && fc_q == OP_FILL_REG
    |-> mem_wdata_o == r_q[7:0] && !mem_bit_o)
    else $error("register fill wrote wrong byte");
  // Done may stand longer while the clock enable is low
  a_mask_noop: assert property ( // [RULE_13]
    state_q == ST_SETUP && ce_i && noop
    |=> (done_o && !mem_req_o) ##1 (!done_o || !$past(ce_i)))
    else $error("zero period mask touched memory");
  a_mask_pattern: assert property ( // [RULE_12]
    mem_req_o && is_mask |-> mem_bit_o &&
    mem_wdata_o[0] == f_mask_bit(ph_q, lead_len, mask_ones))
    else $error("mask bit wrong for phase");
  a_scan_index: assert property ( // [RULE_03]
    reg_we_o && is_scan |-> reg_waddr_o == sdes_q &&
    reg_wdata_o[ADDR_W-1:0] == ((fc_q == OP_SCAN_RIGHT) ?
    idx - {32'h0, pos_q} : idx + {32'h0, pos_q}))
    else $error("scan index written back wrong");
  a_scan_flag: assert property ( // [RULE_06]
    reg_we_o && is_scan |->
    df_set_o == !hit_q && (hit_q || pos_q == len))
    else $error("scan flag does not match miss");
  a_count_clear: assert property ( // [RULE_20]
    reg_we_o && is_bitcnt |->
    reg_waddr_o == tdes_q && reg_wdata_o[WORD_W-1:LEN_W] == 48'h0)
    else $error("count register not cleared above count");
  a_lead_flag: assert property ( // [RULE_19]
    reg_we_o && fc_q == OP_COUNT_LEAD |-> df_set_o == lead_q)
    else $error("leading bit flag wrong");
  // A frozen cycle keeps the S select up one more cycle
  a_decode_regs: assert property ( // [RULE_21]
    state_q == ST_RD_S |-> reg_raddr_o == sdes_q
    ##1 (!$past(ce_i) || reg_raddr_o == tdes_q))
    else $error("register designators read out of order");

  c_scan_hit: cover property (reg_we_o && is_scan && hit_q);
  c_scan_miss: cover property (df_set_o && is_scan);
  c_mask_noop: cover property (state_q == ST_SETUP && noop);
  c_lead_break: cover property (stop && fc_q == OP_COUNT_LEAD);
  c_fill_stall: cover property (mem_req_o && is_fill ##1 !ce_i);
endmodule // bbf_unit

// *** testbench/byte_bit_field_string_unit_tb.sv ***
`timescale 1ns/1ps
module byte_bit_field_string_unit_tb;
  import bbf_pkg::*;
  logic clk_sys_i, rst_i, ce_i, start_i, mem_ack_i;
  logic [31:0] instr_i;
  logic ready_o, done_o, reg_we_o, mem_req_o, mem_we_o, mem_bit_o, df_set_o;
  logic [7:0] reg_raddr_o, reg_waddr_o, mem_wdata_o, mem_rdata_i;
  logic [63:0] reg_rdata_i, reg_wdata_o;
  logic [47:0] mem_addr_o;
  logic [5:0] df_bit_o;
  logic [63:0] rf [0:255];
  logic [7:0] mb [0:511];
  logic [63:0] wb_data;
  logic [7:0] wb_addr;
  logic wb_we, wb_df, stall;
  int err_count, checked, cyc;

  bbf_unit bbf_unit_inst (.clk_sys_i, .rst_i, .ce_i, .start_i, .instr_i,
    .ready_o, .done_o, .reg_raddr_o, .reg_rdata_i, .reg_we_o, .reg_waddr_o,
    .reg_wdata_o, .mem_req_o, .mem_we_o, .mem_bit_o, .mem_addr_o,
    .mem_wdata_o, .mem_rdata_i, .mem_ack_i, .df_set_o, .df_bit_o);

  // Register file and memory answer in the same cycle
  assign reg_rdata_i = rf[reg_raddr_o];
  assign mem_rdata_i = mem_bit_o ?
    {7'h0, mb[mem_addr_o[11:3]][3'd7 - mem_addr_o[2:0]]} :
    mb[mem_addr_o[11:3]];

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (mem_req_o && mem_ack_i && ce_i && mem_we_o) begin
      if (mem_bit_o)
        mb[mem_addr_o[11:3]][3'd7 - mem_addr_o[2:0]] <= mem_wdata_o[0];
      else
        mb[mem_addr_o[11:3]] <= mem_wdata_o;
    end
  end

  function automatic logic gb(input int a);
    return mb[a >> 3][7 - (a % 8)];
  endfunction

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Issue one instruction and capture the write-back at done
  task automatic run(input logic [31:0] ins);
    int n;
    @(negedge clk_sys_i);
    start_i = 1'b1;
    instr_i = ins;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 2000) begin
      if (stall) begin
        ce_i = n[0];
        mem_ack_i = n[1];
      end
      @(negedge clk_sys_i);
      if (!ce_i) chk("req_gated", {63'h0, mem_req_o}, 64'h0);
      n++;
    end
    chk("done", {63'h0, done_o}, 64'h1);
    wb_we = reg_we_o;
    wb_data = reg_wdata_o;
    wb_addr = reg_waddr_o;
    wb_df = df_set_o;
    ce_i = 1'b1;
    mem_ack_i = 1'b1;
    @(negedge clk_sys_i);
  endtask

  task automatic t_scan_right();
    logic [47:0] idx;
    logic [7:0] sb;
    for (int k = 0; k < 2; k++) begin
      idx = k ? -48'd7 : 48'd4;
      sb = 8'h43 + idx[7:0];
      mb[sb] = 8'hff;
      mb[sb - 8'd1] = 8'hff;
      mb[sb - 8'd2] = 8'hff;
      mb[sb - 8'd3] = 8'h12;
      rf[2] = {16'hbeef, idx};
      rf[3] = {16'd4, 48'h200};
      run({OP_SCAN_RIGHT, 8'hff, 8'd2, 8'd3});
      chk("sr_we", {63'h0, wb_we}, 64'h1);
      chk("sr_addr", {56'h0, wb_addr}, 64'h2);
      chk("sr_idx", wb_data, {16'hbeef, idx - 48'd3});
      chk("sr_flag", {63'h0, wb_df}, 64'h0);
    end
    mb[8'h40] = 8'hff;
    mb[8'h41] = 8'hff;
    rf[2] = {16'h1, 48'd0};
    rf[3] = {16'd2, 48'h200};
    run({OP_SCAN_RIGHT, 8'hff, 8'd2, 8'd3});
    chk("sr_miss_idx", wb_data, {16'h1, -48'd2});
    chk("sr_miss_flag", {63'h0, wb_df}, 64'h1);
    chk("df_bit", {58'h0, df_bit_o}, 64'h35);
    $display("test scan_right done");
  endtask

  task automatic t_scan_lr();
    logic [7:0] op [4] = '{OP_SCAN_EQ, OP_SCAN_NE, OP_SCAN_EQ, OP_SCAN_EQ};
    logic [7:0] imm [4] = '{8'h33, 8'h11, 8'h44, 8'h11};
    logic [15:0] ln [4] = '{16'd3, 16'd3, 16'd3, 16'd0};
    logic [47:0] adv [4] = '{48'd2, 48'd1, 48'd3, 48'd0};
    logic fl [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    mb[8'h50] = 8'h11;
    mb[8'h51] = 8'h22;
    mb[8'h52] = 8'h33;
    for (int i = 0; i < 4; i++) begin
      rf[2] = {16'h0, -48'd2};
      rf[3] = {ln[i], 48'h290};
      run({op[i], imm[i], 8'd2, 8'd3});
      chk("slr_idx", wb_data, {16'h0, adv[i] - 48'd2});
      chk("slr_flag", {63'h0, wb_df}, {63'h0, fl[i]});
    end
    $display("test scan_lr done");
  endtask

  task automatic t_fill();
    for (int k = 0; k < 2; k++) begin
      for (int b = 8'h60; b < 8'h66; b++) mb[b] = 8'h00;
      rf[1] = 64'hffffffffffffff3c;
      rf[2] = {16'h0, 48'd1};
      rf[3] = {16'd3, 48'h300};
      stall = k[0];
      run({k ? OP_FILL_REG : OP_FILL_IMM, 8'd1, 8'd2, 8'd3});
      stall = 1'b0;
      chk("fill_we", {63'h0, wb_we}, 64'h0);
      chk("fill_lo", {56'h0, mb[8'h60]}, 64'h0);
      chk("fill_hi", {56'h0, mb[8'h64]}, 64'h0);
      for (int b = 8'h61; b < 8'h64; b++) begin
        if (k) chk("fill_reg", {56'h0, mb[b]}, 64'h3c);
        else chk("fill_imm", {56'h0, mb[b]}, 64'h01);
      end
    end
    $display("test fill done");
  endtask

  task automatic t_mask();
    logic [7:0] op [5] = '{OP_MASK_ZERO, OP_MASK_ONE, OP_MASK_ZERO,
                           OP_MASK_ONE, OP_MASK_ZERO};
    int ld [5] = '{3, 3, 4, 0, 2};
    int pr [5] = '{4, 4, 4, 4, 0};
    logic ones, e, s;
    logic [7:0] bg = 8'h5a;
    for (int c = 0; c < 5; c++) begin
      for (int b = 8'he0; b < 8'he3; b++) mb[b] = bg;
      rf[1] = {16'(ld[c]), 48'h0};
      rf[2] = {16'(pr[c]), 48'h0};
      rf[3] = {16'd10, 48'h703};
      run({op[c], 8'd1, 8'd2, 8'd3});
      ones = (op[c] == OP_MASK_ONE);
      for (int i = -1; i < 11; i++) begin
        e = bg[7 - ((i + 3) % 8)];
        if (pr[c] != 0 && i >= 0 && i < 10)
          e = ((i % pr[c]) < ld[c]) ? ones : !ones;
        s = gb(32'h703 + i);
        chk("mask", {63'h0, s}, {63'h0, e});
      end
    end
    $display("test mask done");
  endtask

  task automatic t_count();
    logic [7:0] op [4] = '{OP_COUNT_LEAD, OP_COUNT_LEAD, OP_COUNT_LEAD,
                           OP_COUNT_ONES};
    logic [47:0] ix [4] = '{48'd2, 48'd2, 48'd12, 48'd2};
    logic [15:0] ln [4] = '{16'd12, 16'd5, 16'd4, 16'd12};
    logic [15:0] cnt [4] = '{16'd9, 16'd4, 16'd3, 16'd10};
    logic fl [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    mb[8'h90] = 8'hff;
    mb[8'h91] = 8'hf0;
    for (int i = 0; i < 4; i++) begin
      rf[1] = {ln[i], 48'h480};
      rf[2] = {16'hffff, ix[i]};
      rf[3] = 64'hffffffffffffffff;
      run({op[i], 8'd1, 8'd2, 8'd3});
      chk("cnt_addr", {56'h0, wb_addr}, 64'h3);
      chk("cnt_val", wb_data, {48'h0, cnt[i]});
      chk("cnt_flag", {63'h0, wb_df}, {63'h0, fl[i]});
    end
    $display("test count done");
  endtask

  initial begin
    wait (cyc == 20000);
    err_count++;
    $display("ERROR timeout expected done seen hang");
    complete_run();
  end

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    start_i = 1'b0;
    instr_i = 32'h0;
    mem_ack_i = 1'b1;
    stall = 1'b0;
    err_count = 0;
    checked = 0;
    cyc = 0;
    for (int i = 0; i < 256; i++) rf[i] = 64'h0;
    for (int i = 0; i < 512; i++) mb[i] = 8'h00;
    repeat (5) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk("rst_ready", {63'h0, ready_o}, 64'h1);
    chk("rst_done", {63'h0, done_o}, 64'h0);
    chk("rst_req", {63'h0, mem_req_o}, 64'h0);
    t_scan_right();
    t_scan_lr();
    t_fill();
    t_mask();
    t_count();
    complete_run();
  end
endmodule // byte_bit_field_string_unit_tb
